// file: hdl/periodic_interrupt_timer.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - sixteen-bit up-counter, free running or wrapping at the modulo value.
// - wrap point comes from the modulo high and low byte registers.
// - counter may be read any time outside wait mode without disturbing the count.
// - prescaler gives seven rates; three-bit select chooses the counter rate.
// - overflow flag sets when counter rolls to zero after matching modulo.
// - interrupt request while enable and overflow flag are set, or while event status and event mask are set.
// - counting continues in wait mode; enabled request wakes the processor.
// - registers are not reachable by the processor during wait mode.
// - stop mode freezes counter and prescaler; resumes where it left.
// - counter holds while break state is active.
// - with break clear enable set, flags clear in break and stay cleared.
// - with break clear enable zero, accesses in break leave flags alone.
// - armed clear holds through protected break; later write completes it.
// - select 0 to 6 divide by 1 to 64; select 7 also 64.
// - clear flag by read with flag set then write zero; overflow cancels.
// - high byte read latches low byte until low byte is read.
// - reset sets stop bit; write-only reset bit clears prescaler, counter.
module periodic_interrupt_timer #(
   parameter int ADDR_W = 12
) (
   input  wire logic              core_clk,      // bus clock, 20 MHz
   input  wire logic              srst,          // sync reset, high
   input  wire pit_pkg::sys_mode_t sys_mode,     // break, wait, stop
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // byte enables
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready,  // read data ready
   output logic                   irq,           // level interrupt
   output logic                   wake_req       // wait-mode wakeup
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam int     PRE_W = pit_pkg::PRE_W;
   pit_pkg::sc_t      sc_q;
   logic [15:0]       cnt_q;
   logic [15:0]       mod_q;
   logic [7:0]        mod_lo_q;
   logic [PRE_W-1:0]  pre_q;
   logic              arm_q;
   logic              inh_q;
   logic [7:0]        lo_buf_q;
   logic              lo_held_q;
   logic              break_clear_enable_q;
   logic              ev_q;
   logic              ev_mask_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic              aw_hold_q;
   logic [7:0]        wdata_q;
   logic              wlane_q;
   logic              w_hold_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [7:0]        rdata_q;

   // mask of prescaler bits that must all be ones for a tick
   function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > pit_pkg::SEL_MAX) ? pit_pkg::SEL_MAX : sel;
      return PRE_W'((7'h01 << s) - 7'h01);
   endfunction

   // register index from a byte address
   function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction

   // ------------------------------------------------------------
   // bus decode and access strobes
   // ------------------------------------------------------------
   logic       ar_take;
   logic       do_write;
   logic       access_ok;
   logic       protect;
   logic [7:0] rd_idx;
   logic [7:0] wr_idx;
   logic       wr_ok;
   logic       rd_sc;
   logic       rd_hi;
   logic       rd_lo;
   logic       wr_sc;
   logic       wr_mh;
   logic       wr_ml;
   logic       wr_is;
   logic       rd_mapped;
   logic       wr_mapped;

   // whole bus shut while in wait mode; bus stays open in stop mode
   assign access_ok = !sys_mode.wait_mode;
   assign protect   = sys_mode.brk && !break_clear_enable_q;
   assign ar_take   = s_axi_arvalid && s_axi_arready;
   assign do_write  = aw_hold_q && w_hold_q && !bvalid_q;
   assign rd_idx    = reg_idx(s_axi_araddr);
   assign wr_idx    = reg_idx(awaddr_q);
   assign rd_mapped = rd_idx >= pit_pkg::IDX_STATUS_CONTROL &&
                      rd_idx <= pit_pkg::IDX_IRQ_MASK;
   assign wr_mapped = wr_idx >= pit_pkg::IDX_STATUS_CONTROL &&
                      wr_idx <= pit_pkg::IDX_IRQ_MASK;
   assign wr_ok     = do_write && access_ok && wlane_q;
   assign rd_sc = ar_take && access_ok &&
                  rd_idx == pit_pkg::IDX_STATUS_CONTROL;
   assign rd_hi = ar_take && access_ok &&
                  rd_idx == pit_pkg::IDX_COUNTER_HIGH;
   assign rd_lo = ar_take && access_ok &&
                  rd_idx == pit_pkg::IDX_COUNTER_LOW;
   assign wr_sc = wr_ok && wr_idx == pit_pkg::IDX_STATUS_CONTROL;
   assign wr_mh = wr_ok && wr_idx == pit_pkg::IDX_MODULO_HIGH;
   assign wr_ml = wr_ok && wr_idx == pit_pkg::IDX_MODULO_LOW;
   assign wr_is = wr_ok && wr_idx == pit_pkg::IDX_IRQ_STATUS;

   // ------------------------------------------------------------
   // prescaler and counter
   // ------------------------------------------------------------
   logic run;
   logic tick;
   logic wrap;
   logic clr;

   assign clr  = wr_sc && wdata_q[pit_pkg::BIT_RST];
   // stop mode and break both freeze counter and prescaler
   assign run  = !sc_q.stop && !sys_mode.stop_mode &&
                 !sys_mode.brk;
   assign tick = run && ((pre_q & div_mask(sc_q.sel)) ==
                         div_mask(sc_q.sel));
   assign wrap = tick && cnt_q == mod_q;

   // prescaler free-runs; reset bit restarts the division
   always_ff @(posedge core_clk) begin
      if (srst || clr) begin
         pre_q <= '0;
      end else if (run) begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // counter; the modulo reset value makes it run free by default
   always_ff @(posedge core_clk) begin
      if (srst || clr) begin
         cnt_q <= '0;
      end else if (wrap) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // status/control and overflow flag
   // ------------------------------------------------------------
   logic flag_set;
   assign flag_set = wrap && !inh_q;

   // control fields and flag in one process so the whole register
   // has a single driver; reset bit is never stored, and a new
   // overflow beats a pending clear write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sc_q.flag <= 1'b0;
         sc_q.ie   <= pit_pkg::SC_RESET[pit_pkg::BIT_IE];
         sc_q.stop <= pit_pkg::SC_RESET[pit_pkg::BIT_STOP];
         sc_q.rst  <= 1'b0;
         sc_q.rsv  <= 1'b0;
         sc_q.sel  <= pit_pkg::SC_RESET[2:0];
      end else begin
         if (wr_sc) begin
            sc_q.ie   <= wdata_q[pit_pkg::BIT_IE];
            sc_q.stop <= wdata_q[pit_pkg::BIT_STOP];
            sc_q.sel  <= wdata_q[2:0];
         end
         if (flag_set) begin
            sc_q.flag <= 1'b1;
         end else if (wr_sc && !wdata_q[pit_pkg::BIT_FLAG] && arm_q &&
                      !protect) begin
            sc_q.flag <= 1'b0;
         end
      end
   end

   // clear arm: read with flag set arms, overflow disarms;
   // a protected break neither arms nor consumes it
   always_ff @(posedge core_clk) begin
      if (srst || flag_set) begin
         arm_q <= 1'b0;
      end else if (rd_sc && sc_q.flag && !protect) begin
         arm_q <= 1'b1;
      end else if (wr_sc && !protect) begin
         arm_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // modulo registers and write inhibit
   // ------------------------------------------------------------
   // high byte write holds off the flag until the low byte lands
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mod_q    <= pit_pkg::MODULO_RESET;
         mod_lo_q <= pit_pkg::MODULO_RESET[7:0];
         inh_q    <= 1'b0;
      end else if (wr_mh) begin
         mod_q[15:8] <= wdata_q;
         inh_q       <= 1'b1;
      end else if (wr_ml) begin
         mod_q[7:0] <= wdata_q;
         mod_lo_q   <= wdata_q;
         inh_q      <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // counter low byte buffer
   // ------------------------------------------------------------
   // snapshot keeps a 16-bit read coherent; count runs on
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lo_buf_q  <= '0;
         lo_held_q <= 1'b0;
      end else if (rd_hi && !lo_held_q) begin
         lo_buf_q  <= cnt_q[7:0];
         lo_held_q <= 1'b1;
      end else if (rd_lo) begin
         lo_held_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // break control and interrupt status/mask
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         break_clear_enable_q    <= 1'b0;
         ev_mask_q <= 1'b0;
      end else if (wr_ok && wr_idx == pit_pkg::IDX_BREAK_CONTROL) begin
         break_clear_enable_q <= wdata_q[pit_pkg::BIT_BREAK_CLEAR_ENABLE];
      end else if (wr_ok && wr_idx == pit_pkg::IDX_IRQ_MASK) begin
         ev_mask_q <= wdata_q[pit_pkg::BIT_EVENT];
      end
   end

   // sticky overflow event; write one clears, set wins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ev_q <= 1'b0;
      end else if (flag_set) begin
         ev_q <= 1'b1;
      end else if (wr_is && wdata_q[pit_pkg::BIT_EVENT] && !protect) begin
         ev_q <= 1'b0;
      end
   end

   // wake request only while enabled flag set, it ends wait mode; irq also follows the masked-in event
   assign wake_req = sc_q.flag && sc_q.ie;
   assign irq      = wake_req || (ev_q && ev_mask_q);

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // address and data are caught in either order
   always_ff @(posedge core_clk) begin
      if (srst || do_write) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
         end
      end
   end

   // payload capture
   always_ff @(posedge core_clk) begin
      if (srst) begin
         awaddr_q <= '0;
         wdata_q  <= '0;
         wlane_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
      end
   end

   // write response; wait mode and holes answer slverr
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= pit_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (access_ok && wr_mapped) ? pit_pkg::RESP_OKAY :
                     pit_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   logic [7:0] rd_val;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = {24'h000000, rdata_q};

   // read mux; reset bit always reads zero
   always_comb begin
      rd_val = 8'h00;
      case (rd_idx)
         pit_pkg::IDX_STATUS_CONTROL: rd_val = {sc_q.flag, sc_q.ie,
                                        sc_q.stop, 2'b00, sc_q.sel};
         pit_pkg::IDX_COUNTER_HIGH:   rd_val = cnt_q[15:8];
         pit_pkg::IDX_COUNTER_LOW:    rd_val = lo_held_q ? lo_buf_q :
                                               cnt_q[7:0];
         pit_pkg::IDX_MODULO_HIGH:    rd_val = mod_q[15:8];
         pit_pkg::IDX_MODULO_LOW:     rd_val = mod_lo_q;
         pit_pkg::IDX_BREAK_CONTROL:  rd_val = {7'h00, break_clear_enable_q};
         pit_pkg::IDX_IRQ_STATUS:     rd_val = {7'h00, ev_q};
         pit_pkg::IDX_IRQ_MASK:       rd_val = {7'h00, ev_mask_q};
         default:                     rd_val = 8'h00;
      endcase
   end

   // one-deep read answer, data from flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rvalid_q <= 1'b0;
         rresp_q  <= pit_pkg::RESP_OKAY;
         rdata_q  <= 8'h00;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rresp_q  <= (access_ok && rd_mapped) ? pit_pkg::RESP_OKAY :
                     pit_pkg::RESP_SLVERR;
         rdata_q  <= access_ok ? rd_val : 8'h00;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   AST_WRAP_ZERO: assert property (wrap && !clr |=> cnt_q == 16'h0000)
      else $error("counter did not wrap to zero");
   AST_FLAG_ON_WRAP: assert property (flag_set |=> sc_q.flag)
      else $error("overflow flag not set on wrap");
   AST_IRQ_GATE: assert property (flag_set && sc_q.ie && !wr_sc
      |=> irq && wake_req)
      else $error("enabled overflow raised no request");
   AST_STOP_FREEZE: assert property (sys_mode.stop_mode && !clr
      |=> cnt_q == $past(cnt_q))
      else $error("counter moved in stop mode");
   AST_BREAK_FREEZE: assert property (sys_mode.brk && !clr
      |=> $stable(cnt_q))
      else $error("counter moved during break");
   AST_BREAK_PROTECT: assert property (protect && sc_q.flag
      |=> sc_q.flag)
      else $error("flag cleared under protected break");
   AST_WAIT_REFUSE: assert property (ar_take && sys_mode.wait_mode
      |=> s_axi_rresp == pit_pkg::RESP_SLVERR)
      else $error("register read in wait mode");
   AST_DIV1_STEP: assert property (run && sc_q.sel == 3'h0 && !clr &&
      cnt_q != mod_q |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not step at divide by one");
   AST_RESET_BIT: assert property (clr |=> cnt_q == 16'h0000 &&
      pre_q == '0)
      else $error("reset bit did not clear counter");
   AST_LATCH_HOLD: assert property (lo_held_q && !rd_lo
      |=> lo_buf_q == $past(lo_buf_q))
      else $error("latched low byte changed");

   COV_WRAP: cover property (flag_set ##[1:20] wake_req);
   COV_CLEAR: cover property (rd_sc && sc_q.flag ##[1:10] !sc_q.flag);
   COV_BREAK: cover property (sys_mode.brk && break_clear_enable_q && wr_sc);
endmodule

// file: hdl/pit_pkg.sv
package pit_pkg;
   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS_CONTROL = 8'h4B;
   localparam logic [7:0] IDX_COUNTER_HIGH   = 8'h4C;
   localparam logic [7:0] IDX_COUNTER_LOW    = 8'h4D;
   localparam logic [7:0] IDX_MODULO_HIGH    = 8'h4E;
   localparam logic [7:0] IDX_MODULO_LOW     = 8'h4F;
   localparam logic [7:0] IDX_BREAK_CONTROL  = 8'h50;
   localparam logic [7:0] IDX_IRQ_STATUS     = 8'h51;
   localparam logic [7:0] IDX_IRQ_MASK       = 8'h52;

   // ------------------------------------------------------------
   // status/control field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_FLAG  = 7;
   localparam int BIT_IE    = 6;
   localparam int BIT_STOP  = 5;
   localparam int BIT_RST   = 4;
   localparam int BIT_BREAK_CLEAR_ENABLE  = 0;
   localparam int BIT_EVENT = 0;
   localparam logic [7:0]  SC_RESET     = 8'h20;
   localparam logic [15:0] MODULO_RESET = 16'hFFFF;
   localparam logic [2:0]  SEL_MAX      = 3'h6;
   localparam int          PRE_W        = 6;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // status/control layout as stored
   typedef struct packed {
      logic       flag;
      logic       ie;
      logic       stop;
      logic       rst;
      logic       rsv;
      logic [2:0] sel;
   } sc_t;

   // system mode inputs from the integration unit
   typedef struct packed {
      logic brk;
      logic wait_mode;
      logic stop_mode;
   } sys_mode_t;
endpackage

// file: verification/periodic_interrupt_timer_tb.sv
`timescale 1ns/1ps
module periodic_interrupt_timer_tb;
   logic core_clk = 0, srst = 1, brk_req = 0, stop_req = 0, wait_go = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wake_req;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [7:0]  rv;
   logic [15:0] c0, c1;
   pit_pkg::sys_mode_t sys_mode;
   int n_mismatch = 0, checks = 0, dv;

   always #25 core_clk = ~core_clk;

   pit_sys_model SYS (.core_clk(core_clk), .srst(srst), .brk_req(brk_req),
      .stop_req(stop_req), .wait_go(wait_go), .wake_req(wake_req),
      .sys_mode(sys_mode));

   periodic_interrupt_timer DUT (.core_clk(core_clk), .srst(srst),
      .sys_mode(sys_mode), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .irq(irq), .wake_req(wake_req));

   // ----------------------------------------
   // bus tasks; release only at the taking edge
   // ----------------------------------------
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge core_clk);
      s_axi_awaddr  <= {2'h0, i, 2'h0};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] i);
      @(posedge core_clk);
      s_axi_araddr  <= {2'h0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ----------------------------------------
   // compares
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input logic [15:0] g);
      checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic rdc(input logic [7:0] i, input logic [7:0] e, input string nm);
      rd(i);
      chk(nm, e, rv);
   endtask

   // high first so the low byte comes from the latch
   task automatic cnt(output logic [15:0] c);
      rd(pit_pkg::IDX_COUNTER_HIGH);
      c[15:8] = rv;
      rd(pit_pkg::IDX_COUNTER_LOW);
      c[7:0] = rv;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog: tests need well under 6000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      wrap_up;
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      rdc(pit_pkg::IDX_STATUS_CONTROL, pit_pkg::SC_RESET, "sc reset");
      rdc(pit_pkg::IDX_MODULO_HIGH, 8'hFF, "mod hi reset");
      rdc(pit_pkg::IDX_MODULO_LOW, 8'hFF, "mod lo reset");
      cnt(c0);
      chk_rng("held count", 0, 0, c0);
      rd(8'h53);
      chk("unmapped resp", {6'h0, pit_pkg::RESP_SLVERR}, {6'h0, resp});
      $display("test reset done");
      // each rate runs 256 cycles from a cleared prescaler and counter
      for (int s = 0; s < 8; s++) begin
         wr(pit_pkg::IDX_STATUS_CONTROL, 8'h10 | s[7:0]);
         repeat (256) @(posedge core_clk);
         wr(pit_pkg::IDX_STATUS_CONTROL, 8'h20 | s[7:0]);
         cnt(c0);
         dv = (s > 5) ? 64 : (1 << s);
         chk_rng("rate count", 256 / dv, 270 / dv + 1, c0);
      end
      $display("test prescale done");
      wr(pit_pkg::IDX_MODULO_HIGH, 8'h00);
      wr(pit_pkg::IDX_MODULO_LOW, 8'h03);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h50);
      repeat (20) @(posedge core_clk);
      cnt(c0);
      chk_rng("wrapped count", 0, 3, c0);
      chk("irq on", 8'h01, {7'h0, irq});
      rd(pit_pkg::IDX_STATUS_CONTROL);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h40);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'hC0, "clear cancelled");
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'hE0);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'hE0, "flag kept");
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h60);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'h60, "flag cleared");
      chk("irq off", 8'h00, {7'h0, irq});
      $display("test overflow done");
      wr(pit_pkg::IDX_IRQ_STATUS, 8'h01);
      rdc(pit_pkg::IDX_IRQ_STATUS, 8'h00, "event cleared");
      wr(pit_pkg::IDX_MODULO_HIGH, 8'h00);
      wr(pit_pkg::IDX_MODULO_LOW, 8'hFF);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h10);
      repeat (300) @(posedge core_clk);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h20);
      chk("irq masked", 8'h00, {7'h0, irq});
      rdc(pit_pkg::IDX_IRQ_STATUS, 8'h01, "event sticky");
      wr(pit_pkg::IDX_IRQ_MASK, 8'h01);
      chk("irq unmasked", 8'h01, {7'h0, irq});
      wr(pit_pkg::IDX_IRQ_STATUS, 8'h01);
      chk("irq cleared", 8'h00, {7'h0, irq});
      $display("test event done");
      // arm the clear, then break with clears protected
      rd(pit_pkg::IDX_STATUS_CONTROL);
      brk_req <= 1'b1;
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h00);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'h80, "flag in break");
      cnt(c0);
      repeat (20) @(posedge core_clk);
      cnt(c1);
      chk_rng("frozen in break", c0, c0, c1);
      brk_req <= 1'b0;
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h20);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'h20, "clear after break");
      $display("test break done");
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h16);
      stop_req <= 1'b1;
      cnt(c0);
      repeat (200) @(posedge core_clk);
      cnt(c1);
      chk_rng("frozen in stop", c0, c0, c1);
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'h06, "sc in stop");
      stop_req <= 1'b0;
      repeat (200) @(posedge core_clk);
      cnt(c1);
      chk_rng("resumed", c0 + 1, c0 + 6, c1);
      $display("test stop done");
      wr(pit_pkg::IDX_MODULO_LOW, 8'h03);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h56);
      wait_go <= 1'b1;
      @(posedge core_clk);
      wait_go <= 1'b0;
      rd(pit_pkg::IDX_STATUS_CONTROL);
      chk("wait resp", {6'h0, pit_pkg::RESP_SLVERR}, {6'h0, resp});
      for (int k = 0; k < 400 && sys_mode.wait_mode; k++) @(posedge core_clk);
      chk("woken", 8'h00, {7'h0, sys_mode.wait_mode});
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'hC6, "flag after wait");
      $display("test wait done");
      // clears allowed in break: armed clear lands and stays done
      wr(pit_pkg::IDX_BREAK_CONTROL, 8'h01);
      brk_req <= 1'b1;
      rd(pit_pkg::IDX_STATUS_CONTROL);
      wr(pit_pkg::IDX_STATUS_CONTROL, 8'h26);
      brk_req <= 1'b0;
      rdc(pit_pkg::IDX_STATUS_CONTROL, 8'h26, "cleared in break");
      $display("test break clear done");
      wrap_up;
   end
endmodule

// file: verification/pit_sys_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// system side: break, wait and stop levels
// ----------------------------------------
module pit_sys_model (
   input  wire logic         core_clk, // bus clock
   input  wire logic         srst,     // sync reset
   input  wire logic         brk_req,  // break level from bench
   input  wire logic         stop_req, // stop level from bench
   input  wire logic         wait_go,  // one-cycle wait entry
   input  wire logic         wake_req, // timer wakeup request
   output pit_pkg::sys_mode_t sys_mode  // modes seen by timer
);
   // wake beats a new entry so the processor never sleeps past a request
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sys_mode <= '0;
      end else begin
         sys_mode.brk       <= brk_req;
         sys_mode.stop_mode <= stop_req;
         if (wake_req) begin
            sys_mode.wait_mode <= 1'b0;
         end else if (wait_go) begin
            sys_mode.wait_mode <= 1'b1;
         end
      end
   end
endmodule
